// ---- rtl/iac_access_control.sv ----
// Access checker for the main switch fabric with flash bank and sector decode.
// Assumes the fabric delivers one request per cycle with slave group and power state.
//
// What this block does
// - grant only pairings the permission matrix allows
// - refuse CPU writes to flash secondary interface
// - CPU reads permitted to all groups
// - debug master reaches every slave group
// - timer transfer units refused at flash secondary
// - power manager writes only from CPU
// - others may still read power manager
// - debug mode bypasses power manager id check
// - powered-off target gets a bus error
// - bank zero sectors 0-3 are 32KB
// - bank zero sectors 4-14 are 128KB
// - bank one has twelve 128KB sectors
// - emulation bank has four 16KB sectors
// - flash banks carry 144-bit data with ECC
// - emulation bank programs during bank 0/1 fetch
// - no instruction fetch from emulation bank
// - banks hold one to sixteen sectors
`timescale 1ns/1ns
`default_nettype none
module iac_access_control #(
  parameter int FLASH_W = iac_pkg::IAC_FLASH_DATA_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire iac_pkg::iac_req_t   req,
  input  wire logic                debug_mode,
  input  wire logic                ee_program,
  input  wire logic [FLASH_W-1:0]  flash_wdata,
  output var  iac_pkg::iac_resp_t  resp,
  output var  logic                ee_program_go,
  output var  logic [FLASH_W-1:0]  flash_data
);

  iac_pkg::iac_master_t master;
  logic                 matrix_ok;
  logic                 pdm_hit;
  logic                 pdm_ok;
  logic                 fetch_ok;
  iac_pkg::iac_bank_t   next_bank;
  logic [3:0]           next_sector;
  logic                 next_fwd;
  logic                 next_err;

  // Debug mode comes from another clock domain, so it is synchronised
  logic dbg_meta;
  logic dbg_sync;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end
    else
    begin
      dbg_meta <= debug_mode;
      dbg_sync <= dbg_meta;
    end
  end

  always_comb
  begin
    case (req.master_id)
      4'h1:    master = iac_pkg::IAC_M_CPU;
      4'h2:    master = iac_pkg::IAC_M_DMA;
      4'h3:    master = iac_pkg::IAC_M_POM;
      4'h4:    master = iac_pkg::IAC_M_DMM;
      4'h5:    master = iac_pkg::IAC_M_DBG;
      4'h6:    master = iac_pkg::IAC_M_TTA;
      4'h7:    master = iac_pkg::IAC_M_TTB;
      default: master = iac_pkg::IAC_M_NONE;
    endcase
  end

  // Permission matrix; refusals are CPU writes and timer units at flash secondary, unknown masters and requests without a slave group
  always_comb
  begin
    matrix_ok = 1'b1;
    if (req.slave == iac_pkg::IAC_S_NONE || master == iac_pkg::IAC_M_NONE)
      matrix_ok = 1'b0;
    else if (req.slave == iac_pkg::IAC_S_FLASH2)
    begin
      case (master)
        iac_pkg::IAC_M_CPU: matrix_ok = !req.write;
        iac_pkg::IAC_M_TTA: matrix_ok = 1'b0;
        iac_pkg::IAC_M_TTB: matrix_ok = 1'b0;
        default:            matrix_ok = 1'b1;
      endcase
    end
  end

  assign pdm_hit = req.addr >= iac_pkg::IAC_PDM_BASE && req.addr <= iac_pkg::IAC_PDM_END;
  // Reads pass; writes need the CPU id unless a debugger holds the device
  assign pdm_ok = !pdm_hit || !req.write
                  || req.master_id == iac_pkg::IAC_CPU_MASTER_ID
                  || dbg_sync;

  // Flash decode
  always_comb
  begin
    next_bank   = iac_pkg::IAC_B_NONE;
    next_sector = 4'h0;
    if (req.addr <= iac_pkg::IAC_B0_SMALL_END)
    begin
      next_bank   = iac_pkg::IAC_B_BANK0;
      next_sector = {2'b00, req.addr[iac_pkg::IAC_SMALL_SHIFT +: 2]};
    end
    else if (req.addr <= iac_pkg::IAC_B0_END)
    begin
      next_bank   = iac_pkg::IAC_B_BANK0;
      next_sector = 4'(req.addr[iac_pkg::IAC_LARGE_SHIFT +: 4] + 4'h3);
    end
    else if (req.addr <= iac_pkg::IAC_B1_END)
    begin
      next_bank   = iac_pkg::IAC_B_BANK1;
      next_sector = 4'((req.addr - iac_pkg::IAC_B1_BASE) >> iac_pkg::IAC_LARGE_SHIFT);
    end
    else if (req.addr >= iac_pkg::IAC_EE_BASE && req.addr <= iac_pkg::IAC_EE_END)
    begin
      next_bank   = iac_pkg::IAC_B_EEPROM;
      next_sector = {2'b00, req.addr[iac_pkg::IAC_EE_SHIFT +: 2]};
    end
  end

  assign fetch_ok = !(req.fetch && next_bank == iac_pkg::IAC_B_EEPROM);

  always_comb
  begin
    next_fwd = 1'b0;
    next_err = 1'b0;
    if (req.valid)
    begin
      if (req.domain_off)
        next_err = 1'b1;
      else if (matrix_ok && pdm_ok && fetch_ok)
        next_fwd = 1'b1;
      else
        next_err = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resp.fwd    <= 1'b0;
      resp.err    <= 1'b0;
      resp.master <= iac_pkg::IAC_M_NONE;
      resp.bank   <= iac_pkg::IAC_B_NONE;
      resp.sector <= 4'h0;
    end
    else
    begin
      resp.fwd    <= next_fwd;
      resp.err    <= next_err;
      resp.master <= master;
      resp.bank   <= next_bank;
      resp.sector <= next_sector;
    end
  end

  // Emulation bank programming is independent of fetch traffic on banks 0/1
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ee_program_go <= 1'b0;
    else
      ee_program_go <= ee_program;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flash_data <= '0;
    else
      flash_data <= flash_wdata;
  end

  tt_flash2_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.domain_off && req.slave == iac_pkg::IAC_S_FLASH2
     && (req.master_id == 4'h6 || req.master_id == 4'h7)) |=> resp.err && !resp.fwd)
    else $error("timer unit reached flash secondary");

  cpu_wr_flash2_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.write && req.master_id == 4'h1 && req.slave == iac_pkg::IAC_S_FLASH2)
    |=> !resp.fwd)
    else $error("cpu write to flash secondary forwarded");

  cpu_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.write && !req.fetch && !req.domain_off && req.master_id == 4'h1
     && req.slave != iac_pkg::IAC_S_NONE) |=> resp.fwd)
    else $error("cpu read refused");

  dbg_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.fetch && !req.domain_off && req.master_id == 4'h5
     && req.slave != iac_pkg::IAC_S_NONE && !(req.write && pdm_hit && !dbg_sync))
    |=> resp.fwd)
    else $error("debug master refused");

  pdm_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.write && pdm_hit && req.master_id != 4'h1 && !dbg_sync)
    |=> resp.err)
    else $error("power manager write from non cpu passed");

  dom_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.domain_off |=> resp.err && !resp.fwd)
    else $error("powered off target not errored");

  resp_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(resp.fwd && resp.err) && (resp.fwd || resp.err) == $past(req.valid && rst_n))
    else $error("response not exactly one of forward or error");

  ee_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.fetch && req.addr >= iac_pkg::IAC_EE_BASE
     && req.addr <= iac_pkg::IAC_EE_END) |=> resp.err && resp.bank == iac_pkg::IAC_B_EEPROM)
    else $error("fetch from emulation bank allowed");

  b0_sector_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'h0002_0000) |=> resp.bank == iac_pkg::IAC_B_BANK0 && resp.sector == 4'h4)
    else $error("bank zero sector four misdecoded");

  b1_sector_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'h002f_ffff) |=> resp.bank == iac_pkg::IAC_B_BANK1 && resp.sector == 4'hb)
    else $error("bank one last sector misdecoded");

  unk_master_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && master == iac_pkg::IAC_M_NONE) |=> resp.err && !resp.fwd)
    else $error("unknown master forwarded");

  slave_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.slave == iac_pkg::IAC_S_NONE) |=> resp.err && !resp.fwd)
    else $error("request without slave group forwarded");

  cpu_wr_other_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.write && !req.fetch && !req.domain_off && req.master_id == 4'h1
     && req.slave != iac_pkg::IAC_S_FLASH2 && req.slave != iac_pkg::IAC_S_NONE)
    |=> resp.fwd)
    else $error("cpu write to open slave refused");

  user_masters_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.fetch && !req.domain_off
     && (req.master_id == 4'h2 || req.master_id == 4'h3 || req.master_id == 4'h4)
     && req.slave != iac_pkg::IAC_S_NONE && !(req.write && pdm_hit && !dbg_sync))
    |=> resp.fwd)
    else $error("user mode master refused");

  tt_other_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.fetch && !req.domain_off
     && (req.master_id == 4'h6 || req.master_id == 4'h7)
     && req.slave != iac_pkg::IAC_S_FLASH2 && req.slave != iac_pkg::IAC_S_NONE
     && !(req.write && pdm_hit && !dbg_sync)) |=> resp.fwd)
    else $error("timer unit refused at open slave");

  pdm_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && !req.write && !req.fetch && !req.domain_off && pdm_hit
     && master != iac_pkg::IAC_M_NONE && req.slave == iac_pkg::IAC_S_PERIPH)
    |=> resp.fwd)
    else $error("power manager read refused");

  dbg_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.write && !req.fetch && !req.domain_off && pdm_hit && dbg_sync
     && master != iac_pkg::IAC_M_NONE && req.slave == iac_pkg::IAC_S_PERIPH)
    |=> resp.fwd)
    else $error("power manager write refused in debug mode");

  b0_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'h0000_0000) |=> resp.bank == iac_pkg::IAC_B_BANK0 && resp.sector == 4'h0)
    else $error("bank zero sector zero misdecoded");

  b0_small_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'h0001_8000) |=> resp.bank == iac_pkg::IAC_B_BANK0 && resp.sector == 4'h3)
    else $error("bank zero sector three misdecoded");

  b1_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'h0018_0000) |=> resp.bank == iac_pkg::IAC_B_BANK1 && resp.sector == 4'h0)
    else $error("bank one first sector misdecoded");

  ee_sector_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.addr == 32'hf020_c000) |=> resp.bank == iac_pkg::IAC_B_EEPROM && resp.sector == 4'h3)
    else $error("emulation bank last sector misdecoded");

  flash_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> flash_data == $past(flash_wdata))
    else $error("flash data word not carried whole");

  ee_prog_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ee_program_go == $past(ee_program))
    else $error("emulation bank program request lost");

  fetch_b01_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.valid && req.fetch && !req.write && !req.domain_off && req.master_id == 4'h1
     && req.slave == iac_pkg::IAC_S_PROG && req.addr <= iac_pkg::IAC_B1_END)
    |=> resp.fwd)
    else $error("fetch from bank zero or one refused");

  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !req.valid |=> !resp.fwd && !resp.err)
    else $error("answer without a request");

endmodule : iac_access_control
`default_nettype wire

// ---- rtl/iac_pkg.sv ----
// Package for the interconnect access checker and flash decoder.
// Assumes one system clock; all users refer to names as iac_pkg::name.
package iac_pkg;

  typedef enum logic [2:0] {
    IAC_M_CPU, IAC_M_DMA, IAC_M_POM, IAC_M_DMM, IAC_M_DBG, IAC_M_TTA, IAC_M_TTB, IAC_M_NONE
  } iac_master_t;

  typedef enum logic [2:0] {
    IAC_S_FLASH2, IAC_S_PROG, IAC_S_CRC, IAC_S_EXTMEM, IAC_S_PERIPH, IAC_S_NONE
  } iac_slave_t;

  typedef enum logic [1:0] {
    IAC_B_NONE, IAC_B_BANK0, IAC_B_BANK1, IAC_B_EEPROM
  } iac_bank_t;

  // Master identifier of the CPU used by the power manager write filter
  localparam logic [3:0] IAC_CPU_MASTER_ID = 4'h1;
  localparam int IAC_FLASH_DATA_W = 144;

  // Flash layout
  localparam logic [31:0] IAC_B0_SMALL_END = 32'h0001_ffff;
  localparam logic [31:0] IAC_B0_END       = 32'h0017_ffff;
  localparam logic [31:0] IAC_B1_BASE      = 32'h0018_0000;
  localparam logic [31:0] IAC_B1_END       = 32'h002f_ffff;
  localparam logic [31:0] IAC_EE_BASE      = 32'hf020_0000;
  localparam logic [31:0] IAC_EE_END       = 32'hf020_ffff;
  localparam int IAC_SMALL_SHIFT = 15;
  localparam int IAC_LARGE_SHIFT = 17;
  localparam int IAC_EE_SHIFT    = 14;
  localparam logic [3:0] IAC_B0_LARGE_FIRST = 4'h4;
  localparam int IAC_MAX_SECTORS = 16;

  // Power manager register frame
  localparam logic [31:0] IAC_PDM_BASE = 32'hffff_0000;
  localparam logic [31:0] IAC_PDM_END  = 32'hffff_01ff;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [3:0]  master_id;
    logic [31:0] addr;
    iac_slave_t  slave;
    logic        domain_off;
  } iac_req_t;

  typedef struct packed {
    logic        fwd;
    logic        err;
    iac_master_t master;
    iac_bank_t   bank;
    logic [3:0]  sector;
  } iac_resp_t;

endpackage : iac_pkg

// ---- tb/iac_slave_model.sv ----
// Slave side of the switch fabric: counts what reaches it and what bounces.
// Assumes the checker's registered response, one cycle per request.
`timescale 1ns/1ns
`default_nettype none
module iac_slave_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire iac_pkg::iac_resp_t resp,
  output var  int                 n_fwd,
  output var  int                 n_err
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      n_fwd <= 0;
      n_err <= 0;
    end
    else
    begin
      n_fwd <= n_fwd + int'(resp.fwd);
      n_err <= n_err + int'(resp.err);
    end
  end
endmodule : iac_slave_model
`default_nettype wire

// ---- tb/interconnect_access_control_bench.sv ----
// Self-checking bench for the access checker and flash decoder.
// Assumes a 25 MHz clock and one-cycle registered answers.
`timescale 1ns/1ns
`default_nettype none
module interconnect_access_control_bench;
  logic               clk = 0, rst_n = 0, debug_mode = 0, ee_program = 0, ee_program_go;
  iac_pkg::iac_req_t  req = '0;
  iac_pkg::iac_resp_t resp;
  logic [143:0]       flash_wdata = '0, flash_data;
  int                 n_fail = 0, checks = 0, n_fwd, n_err, e_fwd = 0, e_err = 0;
  iac_access_control dut (.clk(clk), .rst_n(rst_n), .req(req), .debug_mode(debug_mode),
    .ee_program(ee_program), .flash_wdata(flash_wdata), .resp(resp),
    .ee_program_go(ee_program_go), .flash_data(flash_data));
  iac_slave_model far (.clk(clk), .rst_n(rst_n), .resp(resp), .n_fwd(n_fwd), .n_err(n_err));
  initial forever #20 clk = ~clk;
  task automatic give_verdict;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [143:0] seen, input logic [143:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic access(input logic [3:0] id, input logic wr, input logic fe,
                        input logic [31:0] a, input iac_pkg::iac_slave_t s,
                        input logic off, input logic exp_err);
    @(posedge clk);
    req <= '{valid: 1'b1, write: wr, fetch: fe, master_id: id, addr: a, slave: s,
             domain_off: off};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk("fwd", resp.fwd, !exp_err);
    chk("err", resp.err, exp_err);
    if (exp_err) e_err++;
    else e_fwd++;
  endtask : access
  task automatic matrix_walk;
    logic e;
    for (int id = 0; id < 8; id++)
      for (int wr = 0; wr < 2; wr++)
        for (int s = 0; s < 5; s++)
        begin
          // Unknown master and flash secondary refusals
          e = (id == 0) || (s == 0 && ((id == 1 && wr == 1) || id == 6 || id == 7));
          access(id[3:0], wr[0], 1'b0, 32'h0000_1000, iac_pkg::iac_slave_t'(s), 1'b0, e);
          chk("master", resp.master, (id == 0) ? iac_pkg::IAC_M_NONE
              : iac_pkg::iac_master_t'(id - 1));
        end
  endtask : matrix_walk
  task automatic power_filter;
    for (int id = 1; id < 8; id++)
    begin
      access(id[3:0], 1'b1, 1'b0, 32'hffff_0000, iac_pkg::IAC_S_PERIPH, 1'b0, id != 1);
      access(id[3:0], 1'b0, 1'b0, 32'hffff_01ff, iac_pkg::IAC_S_PERIPH, 1'b0, 1'b0);
    end
    // Debug bypass needs the two-flop synchroniser to settle
    debug_mode <= 1'b1;
    repeat (3) @(posedge clk);
    access(4'h5, 1'b1, 1'b0, 32'hffff_01fc, iac_pkg::IAC_S_PERIPH, 1'b0, 1'b0);
    debug_mode <= 1'b0;
    repeat (3) @(posedge clk);
    access(4'h2, 1'b0, 1'b0, 32'h0000_1000, iac_pkg::IAC_S_CRC, 1'b1, 1'b1);
    access(4'h1, 1'b1, 1'b0, 32'hffff_0000, iac_pkg::IAC_S_PERIPH, 1'b1, 1'b1);
  endtask : power_filter
  task automatic decode(input logic [31:0] a, input iac_pkg::iac_bank_t b, input logic [3:0] s);
    access(4'h2, 1'b0, 1'b0, a, iac_pkg::IAC_S_PROG, 1'b0, 1'b0);
    chk("bank", resp.bank, b);
    if (b != iac_pkg::IAC_B_NONE) chk("sector", resp.sector, s);
  endtask : decode
  task automatic flash_map;
    decode(32'h0000_0000, iac_pkg::IAC_B_BANK0, 4'h0);
    // Erase works on whole sectors, so each sector edge must decode apart
    decode(32'h0000_7fff, iac_pkg::IAC_B_BANK0, 4'h0);
    decode(32'h0000_8000, iac_pkg::IAC_B_BANK0, 4'h1);
    decode(32'h0001_8000, iac_pkg::IAC_B_BANK0, 4'h3);
    decode(32'hf020_c000, iac_pkg::IAC_B_EEPROM, 4'h3);
    decode(32'h0001_ffff, iac_pkg::IAC_B_BANK0, 4'h3);
    decode(32'h0002_0000, iac_pkg::IAC_B_BANK0, 4'h4);
    decode(32'h0017_ffff, iac_pkg::IAC_B_BANK0, 4'he);
    decode(32'h0018_0000, iac_pkg::IAC_B_BANK1, 4'h0);
    decode(32'h002f_ffff, iac_pkg::IAC_B_BANK1, 4'hb);
    decode(32'hf020_0000, iac_pkg::IAC_B_EEPROM, 4'h0);
    decode(32'hf020_ffff, iac_pkg::IAC_B_EEPROM, 4'h3);
    decode(32'h0030_0000, iac_pkg::IAC_B_NONE, 4'h0);
    access(4'h1, 1'b0, 1'b1, 32'hf020_4000, iac_pkg::IAC_S_PROG, 1'b0, 1'b1);
  endtask : flash_map
  task automatic program_during_fetch;
    @(posedge clk);
    ee_program  <= 1'b1;
    flash_wdata <= {16'ha5c3, {4{32'h1234_fedc}}};
    access(4'h1, 1'b0, 1'b1, 32'h0018_0040, iac_pkg::IAC_S_PROG, 1'b0, 1'b0);
    chk("program_go", ee_program_go, 1'b1);
    chk("flash_data", flash_data, {16'ha5c3, {4{32'h1234_fedc}}});
    ee_program <= 1'b0;
  endtask : program_during_fetch
  // Generous bound: about 110 requests at two cycles each
  initial
  begin
    #(40 * 2000);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    chk("reset_master", resp.master, iac_pkg::IAC_M_NONE);
    rst_n <= 1'b1;
    matrix_walk();
    power_filter();
    flash_map();
    program_during_fetch();
    repeat (3) @(posedge clk);
    chk("far_fwd", n_fwd, e_fwd);
    chk("far_err", n_err, e_err);
    give_verdict();
  end
endmodule : interconnect_access_control_bench
`default_nettype wire
